// >>> rtl/scr_map.vh
// constant map for the serial character receiver
`ifndef SCR_MAP_VH
`define SCR_MAP_VH
// =============================================================
// data width and frame options
`define SCR_DATA_W 8
`define SCR_LEN5 5
`define SCR_LEN8 8
// stop length select codes, one per length in units
`define SCR_STOP_1U 2'h0
`define SCR_STOP_15U 2'h1
`define SCR_STOP_2U 2'h2
// =============================================================
// timing: half units per stop code, clock pulse rate limits
`define SCR_HALF_1U 4'h2
`define SCR_HALF_15U 4'h3
`define SCR_HALF_2U 4'h4
`define SCR_SYS_CLK_HZ 100000000
`define SCR_PULSE_NS 400
`define SCR_CLK_PERIOD_NS 10
`define SCR_PULSE_CYC (`SCR_PULSE_NS / `SCR_CLK_PERIOD_NS)
`endif

// >>> rtl/scr_shift.v
// data assembly register for the serial character receiver
`default_nettype none
// =============================================================
// shift register: first bit received ends in bit 1 (lsb)
module scr_shift
#(
  parameter WIDTH = 8
)
(
  input wire clk_in,
  input wire nrst_in,
  input wire clear_in,
  input wire shift_in,
  input wire bit_in,
  input wire five_in,
  input wire load_in,
  output reg [WIDTH-1:0] char_out
);
  reg [WIDTH-1:0] sh;
  wire [WIDTH-1:0] next_sh;
  // load meets the final shift, so it must take the shifted word
  assign next_sh = shift_in ? {bit_in, sh[WIDTH-1:1]} : sh;
  // shift in from the top, align on load
  always @(posedge clk_in)
  begin
    if (!nrst_in || clear_in)
    begin
      sh <= {WIDTH{1'b0}};
      char_out <= {WIDTH{1'b0}};
    end
    else
    begin
      sh <= next_sh;
      if (load_in)
      begin
        if (five_in)
          char_out <= {{(WIDTH-5){1'b0}}, next_sh[WIDTH-1:WIDTH-5]};
        else
          char_out <= next_sh;
      end
    end
  end
endmodule // scr_shift
`default_nettype wire

// >>> rtl/scr_receiver.v
// serial to parallel character receiver, top level
`include "scr_map.vh"
`default_nettype none
// =============================================================
// Overview of operation
// - five or eight data bits, stop of one, one and half, two units
// - start and stop stripped, only data bits delivered in parallel
// - mark line level is one, space level is zero
// - first received bit lands in bit 1, lsb first
// - line watched always; start turns on clock enable and syncs
// - after last data bit the ready flag sets and shows out
// - inhibit input forces clock enable off; keep stable in frame
// - clear input level or pulse clears flag; level blocks setting
// - gated ready is flag and gate input together
// - read pulse makes each one bit output pulse
// - read held steady shows stored bits as levels
// - init input resets internal state
module scr_receiver
(
  // clock and reset
  input wire CLK_IN,
  input wire NRST_IN,
  // configuration
  input wire FIVE_BIT_IN,
  input wire [1:0] STOP_SEL_IN,
  // serial side: line high is mark, external bit clock pulse
  input wire SERIAL_IN,
  input wire BIT_CLK_IN,
  output reg CLK_ENABLE_OUT,
  // host side controls
  input wire INHIBIT_IN,
  input wire FLAG_CLEAR_IN,
  input wire FLAG_GATE_IN,
  input wire READ_IN,
  input wire INIT_IN,
  // host side results
  output reg READY_OUT,
  output reg GATED_READY_OUT,
  output reg [`SCR_DATA_W-1:0] DATA_OUT
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_STOP = 2'h3;
  // =============================================================
  // input synchronisers
  reg [1:0] ser_s;
  reg [1:0] clk_s;
  reg [1:0] inh_s;
  reg [1:0] clr_s;
  reg [1:0] gate_s;
  reg [1:0] rd_s;
  reg [1:0] init_s;
  reg clk_d;
  always @(posedge CLK_IN)
  begin
    if (!NRST_IN)
    begin
      ser_s <= 2'h3;
      clk_s <= 2'h0;
      inh_s <= 2'h0;
      clr_s <= 2'h0;
      gate_s <= 2'h0;
      rd_s <= 2'h0;
      init_s <= 2'h0;
      clk_d <= 1'b0;
    end
    else
    begin
      ser_s <= {ser_s[0], SERIAL_IN};
      clk_s <= {clk_s[0], BIT_CLK_IN};
      inh_s <= {inh_s[0], INHIBIT_IN};
      clr_s <= {clr_s[0], FLAG_CLEAR_IN};
      gate_s <= {gate_s[0], FLAG_GATE_IN};
      rd_s <= {rd_s[0], READ_IN};
      init_s <= {init_s[0], INIT_IN};
      clk_d <= clk_s[1];
    end
  end
  wire line = ser_s[1];
  wire tick = clk_s[1] & ~clk_d; // one pulse per bit clock rising edge
  wire init = init_s[1];
  // =============================================================
  // receive sequencer
  reg [1:0] state;
  reg [3:0] bits;
  reg [3:0] half;
  reg flag;
  wire [3:0] last_bit = FIVE_BIT_IN ? 4'h5 : 4'h8;
  wire [`SCR_DATA_W-1:0] rx_char;
  reg shift;
  reg done;
  // stop length in half units
  function [3:0] stop_halves;
    input [1:0] sel;
    begin
      case (sel)
        `SCR_STOP_1U: stop_halves = `SCR_HALF_1U;
        `SCR_STOP_15U: stop_halves = `SCR_HALF_15U;
        default: stop_halves = `SCR_HALF_2U;
      endcase
    end
  endfunction
  // state machine stepping on bit clock pulses
  always @(posedge CLK_IN)
  begin
    shift <= 1'b0;
    done <= 1'b0;
    if (!NRST_IN || init)
    begin
      state <= ST_IDLE;
      bits <= 4'h0;
      half <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (!line && !inh_s[1])
          begin
            state <= ST_START;
            half <= 4'h0;
          end
        end
        ST_START:
        begin
          if (tick)
          begin
            if (line)
              state <= ST_IDLE;
            else
            begin
              state <= ST_DATA;
              half <= 4'h0;
              bits <= 4'h0;
            end
          end
        end
        ST_DATA:
        begin
          if (tick)
          begin
            half <= half + 4'h1;
            if (half[0])
            begin
              shift <= 1'b1;
              bits <= bits + 4'h1;
              if (bits + 4'h1 == last_bit)
              begin
                state <= ST_STOP;
                half <= 4'h0;
                done <= 1'b1;
              end
            end
          end
        end
        ST_STOP:
        begin
          // stop time counted out
          // last data unit's second half, then the whole stop element;
          // going idle sooner would let a low last bit look like a start
          if (tick)
          begin
            half <= half + 4'h1;
            if (half == stop_halves(STOP_SEL_IN))
              state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // =============================================================
  // data assembly, lsb first aligned to bit 1
  scr_shift #(.WIDTH(`SCR_DATA_W)) u_shift
  (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .clear_in(init),
    .shift_in(shift),
    .bit_in(line),
    .five_in(FIVE_BIT_IN),
    .load_in(done),
    .char_out(rx_char)
  );
  // =============================================================
  // ready flag: a clear level held high blocks setting
  always @(posedge CLK_IN)
  begin
    if (!NRST_IN || init)
      flag <= 1'b0;
    else
    begin
      if (done && !clr_s[1])
        flag <= 1'b1;
      else if (clr_s[1])
        flag <= 1'b0;
    end
  end
  // =============================================================
  // registered outputs
  always @(posedge CLK_IN)
  begin
    if (!NRST_IN)
    begin
      CLK_ENABLE_OUT <= 1'b0;
      READY_OUT <= 1'b0;
      GATED_READY_OUT <= 1'b0;
      DATA_OUT <= {`SCR_DATA_W{1'b0}};
    end
    else
    begin
      CLK_ENABLE_OUT <= (state != ST_IDLE) && !inh_s[1] && !init;
      READY_OUT <= flag;
      GATED_READY_OUT <= flag & gate_s[1];
      DATA_OUT <= rd_s[1] ? rx_char : {`SCR_DATA_W{1'b0}};
    end
  end
endmodule // scr_receiver
`default_nettype wire

// >>> sim/scr_line_model.sv
// line side partner: gated bit clock and serial frame sender
`default_nettype none
// ==========================================================
// pulses only while enabled; frames go out lsb first
module scr_line_model
#(
  parameter int PERIOD = 500,
  parameter int WIDTH = 40
)
(
  input wire logic clk_in,
  input wire logic enable_in,
  output logic bit_clk_out,
  output logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    bit_clk_out = 0;
    serial_out = 1;
    forever
    begin
      @(posedge clk_in);
      if (enable_in)
      begin
        repeat (PERIOD - WIDTH - 1) @(posedge clk_in);
        #1 bit_clk_out = 1;
        repeat (WIDTH) @(posedge clk_in);
        #1 bit_clk_out = 0;
      end
    end
  end
  // start, bits, mark stop, wait for idle
  task automatic send(input logic [7:0] c, input int n);
    serial_out = 0;
    for (int i = 0; i < n; i++)
    begin
      repeat (2) @(negedge bit_clk_out);
      #1 serial_out = c[i];
    end
    repeat (2) @(negedge bit_clk_out);
    #1 serial_out = 1;
    do @(posedge clk_in); while (enable_in);
    // let the last pulse end so it is not counted in the next frame
    while (bit_clk_out) @(posedge clk_in);
    #1;
  endtask
  // hold the line at a level
  task automatic line(input logic v);
    serial_out = v;
  endtask
endmodule // scr_line_model
`default_nettype wire

// >>> sim/scr_receiver_properties.sv
// port timing checker for the serial character receiver
`include "scr_map.vh"
`default_nettype none
// ==========================================================
// assertions on the top level ports
module scr_receiver_properties
(
  input wire CLK_IN,
  input wire NRST_IN,
  input wire SERIAL_IN,
  input wire INHIBIT_IN,
  input wire FLAG_CLEAR_IN,
  input wire FLAG_GATE_IN,
  input wire READ_IN,
  input wire INIT_IN,
  input wire CLK_ENABLE_OUT,
  input wire READY_OUT,
  input wire GATED_READY_OUT,
  input wire [`SCR_DATA_W-1:0] DATA_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  a_inhibit_stops_en: assert property (INHIBIT_IN [*5]
    |-> !CLK_ENABLE_OUT) else $error("enable while inhibited");
  a_start_opens_en: assert property ($rose(CLK_ENABLE_OUT)
    |-> !SERIAL_IN && $past(SERIAL_IN, 3) == 1'b0)
    else $error("enable without start");
  a_ready_in_frame: assert property ($rose(READY_OUT)
    |-> CLK_ENABLE_OUT) else $error("flag outside frame");
  a_clear_blocks: assert property (FLAG_CLEAR_IN [*5]
    |-> !READY_OUT) else $error("flag under clear");
  a_gate_off: assert property ((!FLAG_GATE_IN) [*5]
    |-> !GATED_READY_OUT) else $error("gated flag without gate");
  a_gate_on: assert property ((FLAG_GATE_IN && READY_OUT) [*5]
    |-> GATED_READY_OUT) else $error("gated flag missing");
  a_read_low_zero: assert property ((!READ_IN) [*5]
    |-> DATA_OUT == '0) else $error("data without read");
  a_init_clears: assert property (INIT_IN [*5]
    |-> !READY_OUT && !CLK_ENABLE_OUT) else $error("init ignored");
endmodule // scr_receiver_properties
bind scr_receiver scr_receiver_properties i_prop (.CLK_IN(CLK_IN),
  .NRST_IN(NRST_IN), .SERIAL_IN(SERIAL_IN), .INHIBIT_IN(INHIBIT_IN),
  .FLAG_CLEAR_IN(FLAG_CLEAR_IN), .FLAG_GATE_IN(FLAG_GATE_IN),
  .READ_IN(READ_IN), .INIT_IN(INIT_IN), .CLK_ENABLE_OUT(CLK_ENABLE_OUT),
  .READY_OUT(READY_OUT), .GATED_READY_OUT(GATED_READY_OUT),
  .DATA_OUT(DATA_OUT));
`default_nettype wire

// >>> sim/test_scr_receiver.sv
// self-checking bench for the serial character receiver
`include "scr_map.vh"
`default_nettype none
// ==========================================================
// clock, reset, scenarios and verdict
module test_scr_receiver;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, five, ser, bclk, en, inh, clr, gate, rd, init, rdy, grdy;
  logic [1:0] stop;
  logic [`SCR_DATA_W-1:0] data;
  int n_errors, n_checks, cycles;
  scr_receiver i_dut (.CLK_IN(clk), .NRST_IN(nrst), .FIVE_BIT_IN(five),
    .STOP_SEL_IN(stop), .SERIAL_IN(ser), .BIT_CLK_IN(bclk),
    .CLK_ENABLE_OUT(en), .INHIBIT_IN(inh), .FLAG_CLEAR_IN(clr),
    .FLAG_GATE_IN(gate), .READ_IN(rd), .INIT_IN(init), .READY_OUT(rdy),
    .GATED_READY_OUT(grdy), .DATA_OUT(data));
  scr_line_model i_line (.clk_in(clk), .enable_in(en), .bit_clk_out(bclk),
    .serial_out(ser));
  // free running clock
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one frame, then read, gate and clear the flag
  task automatic t_frame(input logic f, input logic [1:0] s, logic [7:0] c);
    five = f;
    stop = s;
    i_line.send(c, f ? 5 : 8);
    chk("ready", 8'h01, rdy);
    rd = 1;
    cyc(5);
    chk("data", f ? {3'h0, c[4:0]} : c, data);
    rd = 0;
    gate = 1;
    cyc(6);
    chk("gated", 8'h01, grdy);
    gate = 0;
    clr = 1;
    cyc(`SCR_PULSE_CYC);
    clr = 0;
    cyc(5);
    chk("ready", 8'h00, rdy);
    chk("data", 8'h00, data);
  endtask
  // a held clear level keeps the flag down over a frame
  task automatic t_hold;
    five = 0;
    clr = 1;
    i_line.send(8'h3C, 8);
    cyc(2);
    chk("ready", 8'h00, rdy);
    clr = 0;
  endtask
  // inhibit keeps the clock gated off against a start
  task automatic t_inhibit;
    inh = 1;
    cyc(4);
    i_line.line(0);
    cyc(300);
    chk("enable", 8'h00, en);
    i_line.line(1);
    cyc(4);
    inh = 0;
    cyc(4);
  endtask
  // init wipes flag and character
  task automatic t_init;
    i_line.send(8'h81, 8);
    chk("ready", 8'h01, rdy);
    init = 1;
    cyc(5);
    init = 0;
    cyc(3);
    rd = 1;
    cyc(5);
    chk("ready", 8'h00, rdy);
    chk("data", 8'h00, data);
    rd = 0;
  endtask
  // main sequence
  initial
  begin
    {nrst, five, stop, inh, clr, gate, rd, init} = '0;
    cyc(2);
    nrst = 1;
    cyc(3);
    t_frame(0, 2'h0, 8'hA5);
    t_frame(0, 2'h1, 8'h5A);
    t_frame(0, 2'h2, 8'hFF);
    t_frame(0, 2'h3, 8'h01);
    t_frame(1, 2'h1, 8'h16);
    t_frame(1, 2'h0, 8'h09);
    t_hold();
    t_inhibit();
    t_init();
    wrap_up();
  end
endmodule // test_scr_receiver
`default_nettype wire
